// File: logic/bbsg_host.sv
// host-side controller that runs read and write cycles on the sram pins
// assumes the sram sits outside, power-fail level arrives asynchronously
`timescale 1ns/10ps
module bbsg_host
    import bbsg_pkg::*;
(
    input  wire logic              clk_sys_in,       // 10 MHz system clock
    input  wire logic              resetn_in,        // async reset, active low
    input  wire logic              clk_en_in,        // clock enable, freezes state
    input  wire logic              req_valid_in,     // access request
    input  wire logic              req_write_in,     // 1 write, 0 read
    input  wire logic [ADDR_W-1:0] req_addr_in,      // access address
    input  wire logic [DATA_W-1:0] req_wdata_in,     // write data
    input  wire logic              batt_low_in,      // battery_low_flag from sram side
    input  wire logic              power_fail_in,    // supply in power-fail window
    input  wire logic [DATA_W-1:0] data_bus_in,      // data_bus level
    output logic                   req_ready_out,    // request accepted this cycle
    output logic                   done_out,         // access done pulse
    output logic                   refused_out,      // request refused pulse
    output logic [DATA_W-1:0]      rdata_out,        // read data
    output logic                   batt_low_out,     // battery low status
    output logic                   select_n_out,     // chip select, active low
    output logic                   strobe_n_out,     // write strobe, active low
    output logic                   oe_n_out,         // output enable, active low
    output logic [ADDR_W-1:0]      address_bus_out,  // address_bus
    output logic [DATA_W-1:0]      data_bus_out,     // data_bus drive value
    output logic                   data_bus_oe_out   // high while host drives data_bus
);
    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    logic [1:0]        pf_sync_reg;    // power fail two-stage sync
    logic [1:0]        bl_sync_reg;    // battery low two-stage sync
    logic [DATA_W-1:0] db_s1_reg;      // data bus first stage
    logic [DATA_W-1:0] db_s2_reg;      // data bus second stage
    logic              pf_s;           // synced power fail
    logic              bl_s;           // synced battery low

    // two flops before any logic reads a pin
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pf_sync_reg <= 2'h3;
            bl_sync_reg <= 2'h0;
            db_s1_reg   <= '0;
            db_s2_reg   <= '0;
        end else if (clk_en_in) begin
            pf_sync_reg <= {pf_sync_reg[0], power_fail_in};
            bl_sync_reg <= {bl_sync_reg[0], batt_low_in};
            db_s1_reg   <= data_bus_in;
            db_s2_reg   <= db_s1_reg;
        end
    end
    assign pf_s = pf_sync_reg[1];
    assign bl_s = bl_sync_reg[1];

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    bbsg_regs_t s_reg;     // registered state
    bbsg_regs_t s_next;    // next state

    // idle pin image: deselected, strobe high, output enable high, bus released
    function automatic bbsg_pins_t idle_pins(input logic [ADDR_W-1:0] a);
        bbsg_pins_t p;
        p.select_n = 1'b1;
        p.strobe_n = 1'b1;
        p.oe_n     = 1'b1;
        p.addr     = a;
        p.wdata    = '0;
        p.data_oe  = 1'b0;
        return p;
    endfunction

    // ready only while idle with a good supply; a frozen clock never accepts,
    // since the request would be dropped by the held state register
    assign req_ready_out = (s_reg.state == ST_IDLE) && !pf_s && clk_en_in;

    // next-state logic
    always_comb begin
        s_next         = s_reg;
        s_next.done    = 1'b0;
        s_next.refused = 1'b0;
        s_next.batt_low = bl_s;
        case (s_reg.state)
            ST_IDLE: begin
                s_next.pins = idle_pins(s_reg.pins.addr);
                if (req_valid_in && pf_s) begin
                    s_next.refused = 1'b1;
                end else if (req_valid_in) begin
                    s_next.is_write   = req_write_in;
                    s_next.pins.addr  = req_addr_in;
                    s_next.cnt        = CNT_ZERO;
                    if (req_write_in) begin
                        // address and data set up before any strobe falls
                        s_next.pins.wdata   = req_wdata_in;
                        s_next.pins.data_oe = 1'b1;
                        s_next.state        = ST_SETUP;
                    end else begin
                        s_next.pins.select_n = 1'b0;
                        s_next.pins.oe_n     = 1'b0;
                        s_next.state         = ST_READ;
                    end
                end
            end
            ST_SETUP: begin
                if (pf_s) begin
                    // supply failing before the strobe: never start the write,
                    // the pins stay deselected and the access is reported refused
                    s_next.pins    = idle_pins(s_reg.pins.addr);
                    s_next.refused = 1'b1;
                    s_next.cnt     = CNT_ZERO;
                    s_next.state   = ST_RECOVER;
                end else begin
                    // select and strobe fall together: write begins at that edge
                    s_next.pins.select_n = 1'b0;
                    s_next.pins.strobe_n = 1'b0;
                    s_next.pins.oe_n     = 1'b1;
                    s_next.state         = ST_STROBE;
                end
            end
            ST_STROBE: begin
                // address and data held; strobe rises first to end the write
                if (pf_s) begin
                    s_next.pins    = idle_pins(s_reg.pins.addr);
                    s_next.refused = 1'b1;
                    s_next.cnt     = CNT_ZERO;
                    s_next.state   = ST_RECOVER;
                end else if (s_reg.cnt >= CNT_W'(PULSE_CYC - 1)) begin
                    s_next.pins.strobe_n = 1'b1;
                    s_next.cnt           = CNT_ZERO;
                    s_next.state         = ST_RECOVER;
                end else begin
                    s_next.cnt = s_reg.cnt + 4'h1;
                end
            end
            ST_READ: begin
                if (pf_s) begin
                    s_next.pins    = idle_pins(s_reg.pins.addr);
                    s_next.refused = 1'b1;
                    s_next.cnt     = CNT_ZERO;
                    s_next.state   = ST_RECOVER;
                end else if (s_reg.cnt >= CNT_W'(READ_CYC + 1)) begin
                    // two extra cycles cover the data bus synchroniser
                    s_next.rdata = db_s2_reg;
                    s_next.pins  = idle_pins(s_reg.pins.addr);
                    s_next.cnt   = CNT_ZERO;
                    s_next.state = ST_RECOVER;
                end else begin
                    s_next.cnt = s_reg.cnt + 4'h1;
                end
            end
            ST_RECOVER: begin
                // strobe high: release select and bus, keep address for recovery
                s_next.pins.select_n = 1'b1;
                s_next.pins.strobe_n = 1'b1;
                s_next.pins.oe_n     = 1'b1;
                s_next.pins.data_oe  = 1'b0;
                if (s_reg.cnt >= CNT_W'(RECOVERY_CYC - 1)) begin
                    s_next.done  = !s_reg.refused;
                    s_next.state = ST_IDLE;
                end else begin
                    s_next.cnt = s_reg.cnt + 4'h1;
                end
            end
            default: begin
                s_next.state = ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s_reg.state    <= ST_IDLE;
            s_reg.cnt      <= CNT_ZERO;
            s_reg.is_write <= 1'b0;
            s_reg.pins     <= {1'b1, 1'b1, 1'b1, {ADDR_W{1'b0}}, {DATA_W{1'b0}}, 1'b0};
            s_reg.rdata    <= '0;
            s_reg.done     <= 1'b0;
            s_reg.refused  <= 1'b0;
            s_reg.batt_low <= 1'b0;
        end else if (clk_en_in) begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign done_out        = s_reg.done;
    assign refused_out     = s_reg.refused;
    assign rdata_out       = s_reg.rdata;
    assign batt_low_out    = s_reg.batt_low;
    assign select_n_out    = s_reg.pins.select_n;
    assign strobe_n_out    = s_reg.pins.strobe_n;
    assign oe_n_out        = s_reg.pins.oe_n;
    assign address_bus_out = s_reg.pins.addr;
    assign data_bus_out    = s_reg.pins.wdata;
    assign data_bus_oe_out = s_reg.pins.data_oe;
endmodule // bbsg_host

// File: logic/bbsg_pkg.sv
// package for the battery backed sram host-side read and write controller
// assumes a 10 MHz system clock and a 2K x 8 asynchronous sram outside
package bbsg_pkg;
    // ------------------------------------------------------------------
    // geometry and timing
    // ------------------------------------------------------------------
    localparam int          ADDR_W          = 11;    // address_bus width
    localparam int          DATA_W          = 8;     // data_bus width
    localparam int          CLK_PERIOD_NS   = 100;   // system clock period
    localparam int          WRITE_PULSE_NS  = 120;   // strobe low time, slowest grade
    localparam int          RECOVERY_NS     = 10;    // strobe/select recovery time
    localparam int          FLOAT_DELAY_NS  = 60;    // write_output_float_delay
    localparam int          READ_ACCESS_NS  = 200;   // address to data valid
    localparam int          PULSE_CYC       = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          RECOVERY_CYC    = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          FLOAT_CYC       = (FLOAT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          READ_CYC        = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          CNT_W           = 4;     // cycle counter width
    localparam logic [3:0]  CNT_ZERO        = 4'h0;  // counter reset value

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum {ST_IDLE, ST_SETUP, ST_STROBE, ST_READ, ST_RECOVER} bbsg_state_t;

    // pins toward the sram
    typedef struct packed {
        logic              select_n;   // chip select, active low
        logic              strobe_n;   // write strobe, active low
        logic              oe_n;       // output enable, active low
        logic [ADDR_W-1:0] addr;       // address_bus
        logic [DATA_W-1:0] wdata;      // data_bus drive value
        logic              data_oe;    // host drives data_bus
    } bbsg_pins_t;

    // all sequencer state; the input synchronisers sit outside
    typedef struct packed {
        bbsg_state_t       state;      // sequencer state
        logic [CNT_W-1:0]  cnt;        // cycle counter
        logic              is_write;   // current access is a write
        bbsg_pins_t        pins;       // registered pin values
        logic [DATA_W-1:0] rdata;      // captured read data
        logic              done;       // access done pulse
        logic              refused;    // request refused pulse
        logic              batt_low;   // battery_low_flag as last read
    } bbsg_regs_t;
endpackage

// File: tb/bbsg_host_asserts.sv
// checker for the host controller pin sequencing, bound to bbsg_host
// assumes one clock domain and an asynchronous active-low reset
`timescale 1ns/10ps
module bbsg_host_asserts
    import bbsg_pkg::*;
(
    input wire logic              clk_sys_in,      // system clock
    input wire logic              resetn_in,       // reset, active low
    input wire logic              power_fail_in,   // supply fail level
    input wire logic              batt_low_in,     // flag from the sram
    input wire logic              select_n_out,    // chip select
    input wire logic              strobe_n_out,    // write strobe
    input wire logic              oe_n_out,        // output enable
    input wire logic              data_bus_oe_out, // host drives data
    input wire logic              batt_low_out,    // flag status
    input wire logic              done_out,        // access done
    input wire logic [ADDR_W-1:0] address_bus_out  // address_bus
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);
    property p_addr_hold;
        (!select_n_out && !strobe_n_out) |=> $stable(address_bus_out);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved in write");
    property p_recover;
        ($rose(select_n_out) || $rose(strobe_n_out)) |=> (select_n_out && strobe_n_out);
    endproperty
    a_recover: assert property (p_recover) else $error("no recovery cycle");
    property p_oe_write;
        !strobe_n_out |-> (oe_n_out && data_bus_oe_out);
    endproperty
    a_oe_write: assert property (p_oe_write) else $error("bus contention in write");
    property p_pf_idle;
        power_fail_in [*4] |=> (select_n_out && strobe_n_out && !data_bus_oe_out);
    endproperty
    a_pf_idle: assert property (p_pf_idle) else $error("pins active in power fail");
    property p_batt;
        $stable(batt_low_in) [*4] |-> (batt_low_out == batt_low_in);
    endproperty
    a_batt: assert property (p_batt) else $error("battery flag not shown");
    property p_done_idle;
        done_out |-> (select_n_out && strobe_n_out && oe_n_out);
    endproperty
    a_done_idle: assert property (p_done_idle) else $error("done before cycle end");
    c_write: cover property (!select_n_out && !strobe_n_out);
    c_pf: cover property (power_fail_in && !select_n_out);
    c_batt: cover property (batt_low_out && done_out);
endmodule // bbsg_host_asserts
bind bbsg_host bbsg_host_asserts i_chk (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .power_fail_in(power_fail_in), .batt_low_in(batt_low_in), .select_n_out(select_n_out),
    .strobe_n_out(strobe_n_out), .oe_n_out(oe_n_out), .data_bus_oe_out(data_bus_oe_out),
    .batt_low_out(batt_low_out), .done_out(done_out), .address_bus_out(address_bus_out));

// File: tb/bbsg_sram_model.sv
// behavioural battery backed sram, 2K x 8, write mode and power-fail guard
// assumes power-up is the rise of power_up_in; memory starts as addr low byte
`timescale 1ns/10ps
module bbsg_sram_model
    import bbsg_pkg::*;
(
    input  wire logic              power_up_in,   // supply valid edge
    input  wire logic              batt_bad_in,   // battery too weak
    input  wire logic              power_fail_in, // supply in fail window
    input  wire logic              select_n_in,   // chip select
    input  wire logic              strobe_n_in,   // write strobe
    input  wire logic              oe_n_in,       // output enable
    input  wire logic              data_oe_in,    // host drives data_bus
    input  wire logic [ADDR_W-1:0] addr_in,       // address_bus
    input  wire logic [DATA_W-1:0] wdata_in,      // host data
    output logic      [DATA_W-1:0] data_bus_out,  // resolved data_bus
    output logic                   batt_low_out   // battery_low_flag
);
    logic [DATA_W-1:0] mem [2**ADDR_W];      // storage
    logic [DATA_W-1:0] lat_d;                // data seen in write mode
    logic [ADDR_W-1:0] lat_a;                // address seen in write mode
    logic              armed = 1'b0;         // write mode entered
    wire               drv = !power_fail_in && !select_n_in && !oe_n_in && strobe_n_in;
    initial for (int i = 0; i < 2**ADDR_W; i++) mem[i] = i[7:0];
    // battery check at power-up
    always @(posedge power_up_in) batt_low_out = batt_bad_in;
    // a floating bus shows the inverse of the stored byte
    always @* data_bus_out = data_oe_in ? wdata_in : (drv ? mem[addr_in] : ~mem[addr_in]);
    // write mode tracking; commit at the first rising edge
    always @(select_n_in or strobe_n_in or addr_in or wdata_in or power_fail_in) begin
        if (power_fail_in) begin
            armed = 1'b0;
        end else if (!select_n_in && !strobe_n_in) begin
            armed = 1'b1;
            lat_a = addr_in;
            lat_d = wdata_in;
        end else if (armed) begin
            armed = 1'b0;
            if (!batt_low_out) mem[lat_a] = lat_d;
            batt_low_out = 1'b0;
        end
    end
endmodule // bbsg_sram_model

// File: tb/tb.sv
// self-checking bench: host controller against the sram model
// assumes 10 MHz clock and no clock gating
`timescale 1ns/10ps
module tb;
    import bbsg_pkg::*;
    logic clk_sys_in = 1'b0, resetn_in = 1'b0, req_valid_in = 1'b0, req_write_in = 1'b0;
    logic power_fail_in = 1'b0, batt_bad = 1'b1, req_ready_out, done_out, refused_out;
    logic batt_low_out, batt_low_in, select_n_out, strobe_n_out, oe_n_out, data_bus_oe_out;
    logic [ADDR_W-1:0] req_addr_in = '0, address_bus_out;
    logic [DATA_W-1:0] req_wdata_in = '0, rdata_out, data_bus_out, data_bus_in, rd;
    logic [1:0]        res;  // {done, refused}
    int                n_fail = 0, comparisons = 0;
    logic              clk_en = 1'b1;  // clock enable, dropped by the freeze scenario
    always #50 clk_sys_in = ~clk_sys_in;
    bbsg_host i_dut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .clk_en_in(clk_en),
        .req_valid_in(req_valid_in), .req_write_in(req_write_in), .req_addr_in(req_addr_in),
        .req_wdata_in(req_wdata_in), .batt_low_in(batt_low_in), .power_fail_in(power_fail_in),
        .data_bus_in(data_bus_in), .req_ready_out(req_ready_out), .done_out(done_out),
        .refused_out(refused_out), .rdata_out(rdata_out), .batt_low_out(batt_low_out),
        .select_n_out(select_n_out), .strobe_n_out(strobe_n_out), .oe_n_out(oe_n_out),
        .address_bus_out(address_bus_out), .data_bus_out(data_bus_out),
        .data_bus_oe_out(data_bus_oe_out));
    bbsg_sram_model i_mem (.power_up_in(resetn_in), .batt_bad_in(batt_bad),
        .power_fail_in(power_fail_in), .select_n_in(select_n_out), .strobe_n_in(strobe_n_out),
        .oe_n_in(oe_n_out), .data_oe_in(data_bus_oe_out), .addr_in(address_bus_out),
        .wdata_in(data_bus_out), .data_bus_out(data_bus_in), .batt_low_out(batt_low_in));
    task automatic end_of_test;
        if (n_fail == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic cmp(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one access: hold the request until taken or refused, then wait for the answer
    task automatic access(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int i;
        i = 0;
        @(posedge clk_sys_in);
        req_valid_in <= 1'b1;
        req_write_in <= w;
        req_addr_in <= a;
        req_wdata_in <= d;
        do @(negedge clk_sys_in); while (req_ready_out !== 1'b1 && refused_out !== 1'b1 && ++i < 50);
        res = {done_out, refused_out};
        @(posedge clk_sys_in);
        req_valid_in <= 1'b0;
        if (res == 2'b00) begin
            do @(negedge clk_sys_in); while (done_out !== 1'b1 && refused_out !== 1'b1 && ++i < 50);
            res = {done_out, refused_out};
        end
        rd = rdata_out;
    endtask
    task automatic chk_rw(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, e);
        access(1'b1, a, d);
        cmp({6'h00, res}, 8'h02);
        access(1'b0, a, 8'h00);
        cmp(rd, e);
    endtask
    task automatic power_up(input logic bad);
        @(posedge clk_sys_in);
        resetn_in <= 1'b0;
        batt_bad <= bad;
        repeat (16) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        repeat (5) @(posedge clk_sys_in);
    endtask
    task automatic t_batt;
        power_up(1'b1);
        cmp({7'h00, batt_low_out}, 8'h01);
        chk_rw(11'h010, 8'hAA, 8'h10);
        chk_rw(11'h010, 8'h55, 8'h55);
        cmp({7'h00, batt_low_out}, 8'h00);
    endtask
    task automatic t_edges;
        chk_rw(11'h000, 8'h3C, 8'h3C);
        chk_rw(11'h7FF, 8'hC3, 8'hC3);
    endtask
    task automatic t_pfail;
        @(posedge clk_sys_in);
        power_fail_in <= 1'b1;
        repeat (4) @(posedge clk_sys_in);
        access(1'b1, 11'h020, 8'h77);
        cmp({6'h00, res}, 8'h01);
        power_fail_in <= 1'b0;
        repeat (4) @(posedge clk_sys_in);
        chk_rw(11'h030, 8'h5A, 8'h5A);
        access(1'b0, 11'h020, 8'h00);
        cmp(rd, 8'h20);
        fork
            access(1'b1, 11'h030, 8'h99);
            begin repeat (2) @(posedge clk_sys_in); power_fail_in <= 1'b1; end
        join
        cmp({6'h00, res}, 8'h01);
        repeat (4) @(posedge clk_sys_in);
        power_fail_in <= 1'b0;
        repeat (4) @(posedge clk_sys_in);
        access(1'b0, 11'h031, 8'h00);
        cmp(rd, 8'h31);
    endtask
    // a write frozen by the clock enable keeps the strobe low and the address held
    task automatic t_freeze;
        fork
            chk_rw(11'h050, 8'hA5, 8'hA5);
            begin
                repeat (3) @(posedge clk_sys_in);
                clk_en <= 1'b0;
                repeat (2) @(posedge clk_sys_in);
                @(negedge clk_sys_in);
                cmp({7'h00, strobe_n_out}, 8'h00);
                @(posedge clk_sys_in);
                clk_en <= 1'b1;
            end
        join
    endtask
    initial begin
        t_batt();
        t_edges();
        t_freeze();
        t_pfail();
        power_up(1'b0);
        cmp({7'h00, batt_low_out}, 8'h00);
        chk_rw(11'h040, 8'hE1, 8'hE1);
        end_of_test();
    end
    initial begin
        #(3000 * 100);
        n_fail++;
        end_of_test();
    end
endmodule // tb
